/* File: hw/peirq_ahb.sv */
// ahb-lite slave front end: latches the address phase, zero wait states
`timescale 1ns/100ps
module peirq_ahb (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // ahb-lite slave side
  input wire logic i_hsel,
  input wire logic [11:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  // register access strobes toward the core
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [11:0] o_addr
);
  peirq_pkg::peirq_phase_e phase_r;
  logic write_r;
  // capture a valid address phase; data phase follows in the next cycle
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      phase_r <= peirq_pkg::PEIRQ_IDLE;
      write_r <= 1'b0;
      o_addr <= 12'h000;
    end else if (i_hready) begin
      if (i_hsel && i_htrans[1] && i_hsize == 3'h2) begin
        phase_r <= peirq_pkg::PEIRQ_DATA;
        write_r <= i_hwrite;
        o_addr <= i_haddr;
      end else begin
        phase_r <= peirq_pkg::PEIRQ_IDLE;
      end
    end
  end
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_wr_en = (phase_r == peirq_pkg::PEIRQ_DATA) && write_r;
  assign o_rd_en = (phase_r == peirq_pkg::PEIRQ_DATA) && !write_r;
endmodule

/* File: hw/peirq_params.svh */
// register map, field positions and reset values of the event interrupt prescaler
`ifndef PEIRQ_PARAMS_SVH
`define PEIRQ_PARAMS_SVH
`define PEIRQ_OFF_SELECT 12'h000
`define PEIRQ_OFF_PRESCALE 12'h004
`define PEIRQ_OFF_FLAG 12'h008
`define PEIRQ_OFF_CLEAR 12'h00C
`define PEIRQ_OFF_FORCE 12'h010
`define PEIRQ_SEL_IRQ_EN 3
`define PEIRQ_SEL_SRC_LSB 0
`define PEIRQ_PS_PRD_LSB 0
`define PEIRQ_PS_TALLY_LSB 2
`define PEIRQ_FLG_IRQ 0
`define PEIRQ_FLG_CSA 2
`define PEIRQ_FLG_CSB 3
`define PEIRQ_RST_FLAGS 16'h0000
`define PEIRQ_RST_PRD 2'h0
`define PEIRQ_RST_SEL 4'h0
`endif

/* File: hw/peirq_pkg.sv */
// types shared by the event interrupt prescaler files
package peirq_pkg;
  typedef logic [1:0] peirq_tally_t;
  typedef enum logic {
    PEIRQ_IDLE,
    PEIRQ_DATA
  } peirq_phase_e;
endpackage

/* File: hw/peirq_sync.sv */
// two flip-flop synchroniser for the asynchronous pin inputs
`timescale 1ns/100ps
module peirq_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // asynchronous level in, synchronised level out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;
  // first stage feeds only the second stage
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule

/* File: hw/peirq_top.sv */
// event trigger interrupt prescaler with ahb-lite register access
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "peirq_params.svh"
module peirq_top (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [11:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // time-base event levels from the pwm core; lines 1 to 7 are selectable, line 0 never is
  input wire logic [7:0] i_tb_event,
  // conversion-start pulses produced elsewhere, here only latched
  input wire logic i_conv_start_a,
  input wire logic i_conv_start_b,
  // interrupt pulse to the expansion controller
  output logic o_module_irq_pulse
);
  logic wr_en;
  logic rd_en;
  logic [11:0] addr;
  logic [7:0] ev_sync;
  logic [1:0] cs_sync;
  logic [7:0] ev_prev_r;
  logic [3:0] irq_source_select_r;
  logic irq_enable_r;
  peirq_pkg::peirq_tally_t irq_period_select_r;
  peirq_pkg::peirq_tally_t irq_event_tally_r;
  peirq_pkg::peirq_tally_t tally_nxt;
  peirq_pkg::peirq_tally_t prd_nxt;
  logic irq_flag_r;
  logic irq_pending_r;
  logic csa_flag_r;
  logic csb_flag_r;
  logic cs_prev_a_r;
  logic cs_prev_b_r;
  logic event_hit;
  logic wr_prd;
  logic wr_clr;
  logic wr_frc;
  logic reach;
  logic fire;
  logic allow;

  peirq_ahb u_ahb (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hsize(i_hsize),
    .i_hready(i_hready),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .o_wr_en(wr_en),
    .o_rd_en(rd_en),
    .o_addr(addr)
  );

  // event lines come from a foreign timing source, so synchronise them
  peirq_sync #(.WIDTH(10)) u_sync (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_async({i_conv_start_b, i_conv_start_a, i_tb_event}),
    .o_sync({cs_sync, ev_sync})
  );

  // rising edge of the selected source counts as one event
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      ev_prev_r <= 8'h00;
      cs_prev_a_r <= 1'b0;
      cs_prev_b_r <= 1'b0;
    end else begin
      ev_prev_r <= ev_sync;
      cs_prev_a_r <= cs_sync[0];
      cs_prev_b_r <= cs_sync[1];
    end
  end
  // source code zero selects no line, so a stray level on line 0 never counts
  assign event_hit = irq_source_select_r[2:0] != 3'h0 &&
                     ev_sync[irq_source_select_r[2:0]] &&
                     !ev_prev_r[irq_source_select_r[2:0]];

  assign wr_prd = wr_en && addr == `PEIRQ_OFF_PRESCALE;
  assign wr_clr = wr_en && addr == `PEIRQ_OFF_CLEAR && i_hwdata[`PEIRQ_FLG_IRQ];
  assign wr_frc = wr_en && addr == `PEIRQ_OFF_FORCE && i_hwdata[`PEIRQ_FLG_IRQ];
  assign prd_nxt = wr_prd ? i_hwdata[`PEIRQ_PS_PRD_LSB +: 2] : irq_period_select_r;

  // tally advances even in the cycle a new period is written
  always_comb begin
    tally_nxt = irq_event_tally_r;
    if (event_hit && irq_event_tally_r != prd_nxt) begin
      tally_nxt = irq_event_tally_r + 2'h1;
    end
  end

  // the period select is the target count; equality fires too
  // a zero period blocks both counting and force requests
  // compare the next tally with period one, two or three
  assign reach = prd_nxt != 2'h0 && (tally_nxt == prd_nxt || wr_frc);
  // need enable; and need a clear flag or a clear written in the same cycle
  assign allow = irq_enable_r && (!irq_flag_r || wr_clr);
  assign fire = allow && (reach || irq_pending_r) && prd_nxt != 2'h0;

  // control registers written by software
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      irq_source_select_r <= `PEIRQ_RST_SEL;
      irq_enable_r <= 1'b0;
      irq_period_select_r <= `PEIRQ_RST_PRD;
    end else begin
      if (wr_en && addr == `PEIRQ_OFF_SELECT) begin
        irq_source_select_r <= i_hwdata[`PEIRQ_SEL_SRC_LSB +: 4];
        irq_enable_r <= i_hwdata[`PEIRQ_SEL_IRQ_EN];
      end
      if (wr_prd) begin
        irq_period_select_r <= i_hwdata[`PEIRQ_PS_PRD_LSB +: 2];
      end
    end
  end

  // tally cleared on each pulse; it holds at the period
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      irq_event_tally_r <= 2'h0;
    end else if (fire) begin
      irq_event_tally_r <= 2'h0;
    end else if (prd_nxt != 2'h0) begin
      irq_event_tally_r <= tally_nxt;
    end
  end

  // one pending slot, filled when the period is hit while enabled but blocked by the flag
  // the tally parks at the period while blocked, so one bit is enough here
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      irq_pending_r <= 1'b0;
    end else if (fire || prd_nxt == 2'h0) begin
      irq_pending_r <= 1'b0;
    end else if (reach && irq_enable_r) begin
      irq_pending_r <= 1'b1;
    end
  end

  // interrupt flag and pulse; a new pulse beats a clear in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      irq_flag_r <= 1'b0;
      o_module_irq_pulse <= 1'b0;
    end else begin
      o_module_irq_pulse <= fire;
      if (fire) begin
        irq_flag_r <= 1'b1;
      end else if (wr_clr) begin
        irq_flag_r <= 1'b0;
      end
    end
  end

  // conversion-start flags latch and block nothing; set beats clear
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      csa_flag_r <= 1'b0;
      csb_flag_r <= 1'b0;
    end else begin
      if (cs_sync[0] && !cs_prev_a_r) begin
        csa_flag_r <= 1'b1;
      end else if (wr_en && addr == `PEIRQ_OFF_CLEAR && i_hwdata[`PEIRQ_FLG_CSA]) begin
        csa_flag_r <= 1'b0;
      end
      if (cs_sync[1] && !cs_prev_b_r) begin
        csb_flag_r <= 1'b1;
      end else if (wr_en && addr == `PEIRQ_OFF_CLEAR && i_hwdata[`PEIRQ_FLG_CSB]) begin
        csb_flag_r <= 1'b0;
      end
    end
  end

  // read mux; unmapped and write-only words read zero
  always_comb begin
    o_hrdata = 32'h0000_0000;
    if (rd_en) begin
      case (addr)
        `PEIRQ_OFF_SELECT: begin
          o_hrdata[`PEIRQ_SEL_SRC_LSB +: 4] = irq_source_select_r;
          o_hrdata[`PEIRQ_SEL_IRQ_EN] = irq_enable_r;
        end
        // tally is visible beside the period
        `PEIRQ_OFF_PRESCALE: begin
          o_hrdata[`PEIRQ_PS_PRD_LSB +: 2] = irq_period_select_r;
          o_hrdata[`PEIRQ_PS_TALLY_LSB +: 2] = irq_event_tally_r;
        end
        `PEIRQ_OFF_FLAG: begin
          o_hrdata[`PEIRQ_FLG_IRQ] = irq_flag_r;
          o_hrdata[`PEIRQ_FLG_CSA] = csa_flag_r;
          o_hrdata[`PEIRQ_FLG_CSB] = csb_flag_r;
        end
        default: o_hrdata = 32'h0000_0000;
      endcase
    end
  end

  // pulse needs enable and a nonzero period
  a_pulse_needs_enable: assert property (@(posedge i_clock) disable iff (i_srst)
    o_module_irq_pulse |-> $past(irq_enable_r) && $past(prd_nxt) != 2'h0)
    else $error("irq pulse without enable or period");
  a_pulse_sets_flag: assert property (@(posedge i_clock) disable iff (i_srst)
    o_module_irq_pulse |-> irq_flag_r)
    else $error("flag not set with pulse");
  a_flag_blocks_pulse: assert property (@(posedge i_clock) disable iff (i_srst)
    irq_flag_r && !wr_clr |=> !o_module_irq_pulse)
    else $error("pulse while flag set");
  a_tally_cleared: assert property (@(posedge i_clock) disable iff (i_srst)
    fire |=> irq_event_tally_r == 2'h0)
    else $error("tally not cleared");
  a_zero_period_idle: assert property (@(posedge i_clock) disable iff (i_srst)
    irq_period_select_r == 2'h0 && !wr_prd |=> $stable(irq_event_tally_r))
    else $error("tally moved with zero period");
  a_tally_holds: assert property (@(posedge i_clock) disable iff (i_srst)
    irq_flag_r && irq_event_tally_r == irq_period_select_r && !wr_prd && !wr_clr
      |=> irq_event_tally_r == $past(irq_event_tally_r))
    else $error("tally passed period");
  a_pending_release: assert property (@(posedge i_clock) disable iff (i_srst)
    irq_pending_r && wr_clr && irq_enable_r && irq_period_select_r != 2'h0 && !wr_prd
      |=> o_module_irq_pulse)
    else $error("pending irq lost");
  a_clear_works: assert property (@(posedge i_clock) disable iff (i_srst)
    wr_clr && !fire |=> !irq_flag_r)
    else $error("flag not cleared");

  // checks on counting and the side flags, all on the one clock
  // event reaching period fires
  a_period_fires: assert property (@(posedge i_clock) disable iff (i_srst)
    event_hit && irq_enable_r && !irq_flag_r && !wr_prd && irq_period_select_r != 2'h0 &&
      irq_event_tally_r + 2'h1 == irq_period_select_r |=> o_module_irq_pulse)
    else $error("no pulse at period");
  a_count_step: assert property (@(posedge i_clock) disable iff (i_srst)
    event_hit && !fire && prd_nxt != 2'h0 && irq_event_tally_r != prd_nxt
      |=> irq_event_tally_r == $past(irq_event_tally_r) + 2'h1)
    else $error("tally missed an event");
  a_equal_write_fires: assert property (@(posedge i_clock) disable iff (i_srst)
    wr_prd && prd_nxt == irq_event_tally_r && prd_nxt != 2'h0 && irq_enable_r && !irq_flag_r
      |=> o_module_irq_pulse)
    else $error("no pulse on equal period write");
  a_disabled_silent: assert property (@(posedge i_clock) disable iff (i_srst)
    !irq_enable_r |=> !o_module_irq_pulse)
    else $error("pulse while disabled");
  a_pending_consumed: assert property (@(posedge i_clock) disable iff (i_srst)
    fire |=> !irq_pending_r)
    else $error("pending slot kept after pulse");
  a_force_ignored: assert property (@(posedge i_clock) disable iff (i_srst)
    wr_frc && prd_nxt == 2'h0 |=> !o_module_irq_pulse)
    else $error("force fired with zero period");
  a_flag_read_only: assert property (@(posedge i_clock) disable iff (i_srst)
    wr_en && addr == `PEIRQ_OFF_FLAG && !fire
      |=> irq_flag_r == $past(irq_flag_r))
    else $error("flag changed by a write");
  a_conv_a_latch: assert property (@(posedge i_clock) disable iff (i_srst)
    cs_sync[0] && !cs_prev_a_r |=> csa_flag_r)
    else $error("conv start a flag not latched");
  a_conv_b_latch: assert property (@(posedge i_clock) disable iff (i_srst)
    cs_sync[1] && !cs_prev_b_r |=> csb_flag_r)
    else $error("conv start b flag not latched");
endmodule

/* File: verif/peirq_cpu_model.sv */
// stand-in for the interrupt expansion controller: counts interrupt pulses
`timescale 1ns/100ps
module peirq_cpu_model (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // interrupt pulse from the block
  input wire logic i_irq,
  // number of pulses taken so far
  output int o_count
);
  // a pulse lasts one cycle, so every high cycle is one request
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_count <= 0;
    end else if (i_irq === 1'b1) begin
      o_count <= o_count + 1;
    end
  end
endmodule

/* File: verif/tb.sv */
// self-checking bench for the event interrupt prescaler
`timescale 1ns/100ps
`include "peirq_params.svh"
module tb;
  logic clk, srst, hsel, hwrite, csa, csb;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, rdata;
  logic rresp;
  logic [7:0] tbev;
  wire logic hready;
  wire logic irq;
  wire logic hresp;
  wire logic [31:0] hrdata;
  int err_count, comparisons, nirq, seen_irq;
  peirq_top peirq_top_i (.i_clock(clk), .i_srst(srst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_tb_event(tbev), .i_conv_start_a(csa), .i_conv_start_b(csb),
    .o_module_irq_pulse(irq));
  peirq_cpu_model peirq_cpu_model_i (.i_clock(clk), .i_srst(srst), .i_irq(irq),
    .o_count(seen_irq));
  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one single word transfer; address phase held until hready is seen high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rdata = hrdata;
    rresp = hresp;
  endtask
  task automatic rdck(input logic [11:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0000_0000);
    chk(what, rdata, exp);
    chk({what, " resp"}, 32'(rresp), 32'h0);
  endtask
  task automatic irqck(input string what);
    chk(what, 32'(seen_irq), 32'(nirq));
  endtask
  // events on source line 1; slow enough for the pin synchroniser
  task automatic ev(input int n);
    repeat (n) begin
      tbev[1] <= 1'b1;
      repeat (3) @(posedge clk);
      tbev[1] <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic test_done;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    test_done();
  end
  initial begin
    {hsel, hwrite, csa, csb, haddr, htrans, hwdata, tbev} = '0;
    hsize = 3'h2;
    srst = 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdck(`PEIRQ_OFF_FLAG, 32'h0, "flags reset");
    rdck(`PEIRQ_OFF_PRESCALE, 32'h0, "prescale reset");
    xfer(1'b1, `PEIRQ_OFF_FLAG, 32'h0000_000D);
    rdck(`PEIRQ_OFF_FLAG, 32'h0, "flags read only");
    rdck(12'h100, 32'h0, "unmapped");
    // period zero: events and force are both ignored
    xfer(1'b1, `PEIRQ_OFF_SELECT, 32'h9);
    ev(2);
    xfer(1'b1, `PEIRQ_OFF_FORCE, 32'h1);
    rdck(`PEIRQ_OFF_PRESCALE, 32'h0, "tally off");
    irqck("no irq period 0");
    // every period write below is at or above the tally
    for (int p = 1; p <= 3; p++) begin
      xfer(1'b1, `PEIRQ_OFF_PRESCALE, 32'(p));
      for (int k = 1; k < p; k++) begin
        ev(1);
        rdck(`PEIRQ_OFF_PRESCALE, 32'(p | (k << 2)), "tally");
      end
      irqck("no early irq");
      ev(1);
      nirq++;
      irqck("irq at period");
      rdck(`PEIRQ_OFF_PRESCALE, 32'(p), "tally cleared");
      rdck(`PEIRQ_OFF_FLAG, 32'h1, "irq flag");
      xfer(1'b1, `PEIRQ_OFF_CLEAR, 32'h1);
    end
    // flag held: one event waits, a second is lost
    xfer(1'b1, `PEIRQ_OFF_PRESCALE, 32'h1);
    ev(1);
    nirq++;
    ev(2);
    irqck("blocked by flag");
    xfer(1'b1, `PEIRQ_OFF_CLEAR, 32'h0);
    rdck(`PEIRQ_OFF_FLAG, 32'h1, "clear zero");
    xfer(1'b1, `PEIRQ_OFF_CLEAR, 32'h1);
    repeat (3) @(posedge clk);
    nirq++;
    irqck("pending issued");
    xfer(1'b1, `PEIRQ_OFF_CLEAR, 32'h1);
    repeat (3) @(posedge clk);
    irqck("one pending only");
    xfer(1'b1, `PEIRQ_OFF_FORCE, 32'h1);
    repeat (3) @(posedge clk);
    nirq++;
    irqck("force fires");
    // disabled: tally stops at the period and nothing fires
    xfer(1'b1, `PEIRQ_OFF_CLEAR, 32'h1);
    xfer(1'b1, `PEIRQ_OFF_SELECT, 32'h1);
    xfer(1'b1, `PEIRQ_OFF_PRESCALE, 32'h2);
    ev(3);
    rdck(`PEIRQ_OFF_PRESCALE, 32'hA, "tally holds");
    irqck("disabled");
    xfer(1'b1, `PEIRQ_OFF_PRESCALE, 32'h3);
    xfer(1'b1, `PEIRQ_OFF_SELECT, 32'h9);
    xfer(1'b1, `PEIRQ_OFF_PRESCALE, 32'h2);
    repeat (3) @(posedge clk);
    nirq++;
    irqck("period equals tally");
    rdck(`PEIRQ_OFF_PRESCALE, 32'h2, "tally after write");
    // conversion-start flags latch and clear one by one
    csa <= 1'b1;
    csb <= 1'b1;
    repeat (3) @(posedge clk);
    {csa, csb} <= 2'b00;
    repeat (4) @(posedge clk);
    rdck(`PEIRQ_OFF_FLAG, 32'hD, "conv flags");
    xfer(1'b1, `PEIRQ_OFF_CLEAR, 32'h4);
    rdck(`PEIRQ_OFF_FLAG, 32'h9, "conv a cleared");
    xfer(1'b1, `PEIRQ_OFF_CLEAR, 32'h8);
    rdck(`PEIRQ_OFF_FLAG, 32'h1, "conv b cleared");
    // event edge lands in the data phase of a period write (tally 0, new period 3)
    tbev[1] <= 1'b1;
    @(posedge clk);
    xfer(1'b1, `PEIRQ_OFF_PRESCALE, 32'h3);
    tbev[1] <= 1'b0;
    repeat (4) @(posedge clk);
    rdck(`PEIRQ_OFF_PRESCALE, 32'h7, "event with write");
    irqck("no irq while flag set");
    test_done();
  end
endmodule
